/* File: core/aehl_axis.sv */
// axis feedback block: decoder, limits, homing, error and axi4-lite regs
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - an active limit input removes drive excitation from the axis
// - each limit input polarity is set high or low independently
// - quadrature phases decode at times four, one count per edge
// - decoder keeps up with 16 MHz count rates without loss
// - switch homing loads the position counter with a chosen value
// - a home event ramps the axis down or stops it at once
// - home level, travel direction and stop response are set by command
// - home-encoder mode needs index, home and one quadrant together
// - default home pattern is A high, B low, index and home
// - home high, home low and pattern commands change the home pattern
// - inverting one phase or swapping phases reverses counting
// - slip detection and geared tracking are each enabled by command
// - after a move ends the position error is offered for correction
// - position error feeds the servo filter continuously
module aehl_axis (
  input  wire logic        SYS_CLK,
  input  wire logic        RESETN,
  input  wire logic        ENC_A,
  input  wire logic        ENC_B,
  input  wire logic        ENC_INDEX,
  input  wire logic        HOME_SW,
  input  wire logic        LIMIT_POS,
  input  wire logic        LIMIT_NEG,
  input  wire logic [31:0] COMMAND_POS,
  input  wire logic        MOVE_DONE,
  output logic             EXCITE_EN,
  output logic             HOME_STOP_RAMP,
  output logic             HOME_STOP_NOW,
  output logic             HOME_DIR,
  output logic      [31:0] ENC_POS,
  output logic      [31:0] POS_ERR,
  output logic             SLIP,
  output logic             CORR_VALID,
  output logic      [31:0] CORR_AMT,
  output logic      [31:0] TRACK_TARGET,
  output logic             IRQ,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic      [1:0]  S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic      [31:0] S_AXI_RDATA,
  output logic      [1:0]  S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);
  typedef struct packed {
    logic                          aw_got;
    logic [7:0]                    aw_addr;
    logic                          w_got;
    logic [31:0]                   w_data;
    logic [3:0]                    w_strb;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          rvalid;
    logic [1:0]                    rresp;
    logic [31:0]                   rdata;
    logic [aehl_pkg::CTRL_W-1:0]   ctrl;
    logic [31:0]                   home_val;
    logic [2:0]                    home_pat;
    logic [31:0]                   slip_tol;
    logic [15:0]                   gear;
    logic [aehl_pkg::IRQ_W-1:0]    irq_stat;
    logic [aehl_pkg::IRQ_W-1:0]    irq_mask;
    logic                          lim_pos_act;
    logic                          lim_neg_act;
    logic                          stop_ramp;
    logic                          stop_now;
    logic [31:0]                   pos_err;
    logic                          slip;
    logic                          done_d;
    logic                          corr_valid;
    logic [31:0]                   corr_amt;
    logic [31:0]                   track;
    logic                          pos_load;
    logic [31:0]                   pos_load_val;
  } aehl_axis_st_t;

  aehl_axis_st_t st_r;
  aehl_axis_st_t st_nxt;

  logic        pha;
  logic        phb;
  logic [31:0] count;
  logic        bad_step;
  logic        home_act;
  logic        home_evt;
  logic        wr_fire;
  logic [31:0] err_abs;
  logic [aehl_pkg::IRQ_W-1:0] ev;
  logic [31:0] mrg;

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic mapped(input logic [7:0] a);
    return (a == aehl_pkg::ADDR_CTRL)     || (a == aehl_pkg::ADDR_HOME_VAL)
        || (a == aehl_pkg::ADDR_POSITION) || (a == aehl_pkg::ADDR_HOME_PAT)
        || (a == aehl_pkg::ADDR_SLIP_TOL) || (a == aehl_pkg::ADDR_GEAR)
        || (a == aehl_pkg::ADDR_STATUS)   || (a == aehl_pkg::ADDR_IRQ_STAT)
        || (a == aehl_pkg::ADDR_IRQ_MASK);
  endfunction : mapped

  // phase conditioning; swap or single inversion flips count direction
  always_comb begin
    logic ia;
    logic ib;
    ia  = ENC_A ^ st_r.ctrl[aehl_pkg::CTRL_INV_A];
    ib  = ENC_B ^ st_r.ctrl[aehl_pkg::CTRL_INV_B];
    pha = st_r.ctrl[aehl_pkg::CTRL_SWAP_AB] ? ib : ia;
    phb = st_r.ctrl[aehl_pkg::CTRL_SWAP_AB] ? ia : ib;
  end

  aehl_quad u_quad (
    .SYS_CLK  (SYS_CLK),
    .RESETN   (RESETN),
    .PHA      (pha),
    .PHB      (phb),
    .LOAD     (st_r.pos_load),
    .LOAD_VAL (st_r.pos_load_val),
    .COUNT    (count),
    .BAD_STEP (bad_step)
  );

  aehl_home u_home (
    .SYS_CLK  (SYS_CLK),
    .RESETN   (RESETN),
    .ENC_MODE (st_r.ctrl[aehl_pkg::CTRL_HOME_ENC]),
    .HOME_HI  (st_r.ctrl[aehl_pkg::CTRL_HOME_HI]),
    .PATTERN  (st_r.home_pat),
    .PHA      (pha),
    .PHB      (phb),
    .INDEX    (ENC_INDEX),
    .HOME_IN  (HOME_SW),
    .ARMED    (st_r.ctrl[aehl_pkg::CTRL_HOME_ARM]),
    .HOME_ACT (home_act),
    .HOME_EVT (home_evt)
  );

  assign wr_fire = st_r.aw_got && st_r.w_got && !st_r.bvalid;

  always_comb begin
    st_nxt  = st_r;
    mrg     = 32'h0000_0000;
    err_abs = st_r.pos_err[31] ? (32'h0 - st_r.pos_err) : st_r.pos_err;
    // limits, each with its own active level
    st_nxt.lim_pos_act = LIMIT_POS
                         == st_r.ctrl[aehl_pkg::CTRL_LIM_POS_HI];
    st_nxt.lim_neg_act = LIMIT_NEG
                         == st_r.ctrl[aehl_pkg::CTRL_LIM_NEG_HI];
    // servo error, refreshed every clock
    st_nxt.pos_err = COMMAND_POS - count;
    st_nxt.slip    = st_r.ctrl[aehl_pkg::CTRL_SLIP_EN]
                     && (err_abs > st_r.slip_tol);
    if (st_r.ctrl[aehl_pkg::CTRL_TRACK_EN]) begin
      st_nxt.track = 32'(count[15:0]) * 32'(st_r.gear);
    end
    st_nxt.done_d     = MOVE_DONE;
    st_nxt.corr_valid = 1'b0;
    if (MOVE_DONE && !st_r.done_d
        && st_r.ctrl[aehl_pkg::CTRL_CORRECT_EN]) begin
      st_nxt.corr_valid = 1'b1;
      st_nxt.corr_amt   = st_r.pos_err;
    end
    // home event: load position, stop as configured, disarm
    st_nxt.pos_load     = home_evt;
    st_nxt.pos_load_val = st_r.home_val;
    st_nxt.stop_ramp    = home_evt
                          && !st_r.ctrl[aehl_pkg::CTRL_STOP_NOW];
    st_nxt.stop_now     = home_evt
                          && st_r.ctrl[aehl_pkg::CTRL_STOP_NOW];
    if (home_evt) begin
      st_nxt.ctrl[aehl_pkg::CTRL_HOME_ARM] = 1'b0;
    end
    // write channel, address and data in either order
    if (S_AXI_AWVALID && !st_r.aw_got && !st_r.bvalid) begin
      st_nxt.aw_got  = 1'b1;
      st_nxt.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !st_r.w_got && !st_r.bvalid) begin
      st_nxt.w_got  = 1'b1;
      st_nxt.w_data = S_AXI_WDATA;
      st_nxt.w_strb = S_AXI_WSTRB;
    end
    if (wr_fire) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = mapped(st_r.aw_addr) ? aehl_pkg::RESP_OKAY
                                           : aehl_pkg::RESP_SLVERR;
      case (st_r.aw_addr)
        aehl_pkg::ADDR_CTRL: begin
          mrg         = merge(32'(st_r.ctrl), st_r.w_data, st_r.w_strb);
          st_nxt.ctrl = mrg[aehl_pkg::CTRL_W-1:0];
        end
        aehl_pkg::ADDR_HOME_VAL: begin
          st_nxt.home_val = merge(st_r.home_val, st_r.w_data, st_r.w_strb);
        end
        aehl_pkg::ADDR_HOME_PAT: begin
          mrg             = merge(32'(st_r.home_pat), st_r.w_data,
                                  st_r.w_strb);
          st_nxt.home_pat = mrg[2:0];
        end
        aehl_pkg::ADDR_SLIP_TOL: begin
          st_nxt.slip_tol = merge(st_r.slip_tol, st_r.w_data, st_r.w_strb);
        end
        aehl_pkg::ADDR_GEAR: begin
          mrg         = merge(32'(st_r.gear), st_r.w_data, st_r.w_strb);
          st_nxt.gear = mrg[15:0];
        end
        aehl_pkg::ADDR_IRQ_MASK: begin
          mrg             = merge(32'(st_r.irq_mask), st_r.w_data,
                                  st_r.w_strb);
          st_nxt.irq_mask = mrg[aehl_pkg::IRQ_W-1:0];
        end
        default: st_nxt.bresp = st_nxt.bresp;
      endcase
    end
    if (st_r.bvalid && S_AXI_BREADY) begin
      st_nxt.bvalid = 1'b0;
    end
    // read channel; reading the interrupt status clears it
    if (st_r.rvalid && S_AXI_RREADY) begin
      st_nxt.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && !st_r.rvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = mapped(S_AXI_ARADDR) ? aehl_pkg::RESP_OKAY
                                           : aehl_pkg::RESP_SLVERR;
      case (S_AXI_ARADDR)
        aehl_pkg::ADDR_CTRL:     st_nxt.rdata = 32'(st_r.ctrl);
        aehl_pkg::ADDR_HOME_VAL: st_nxt.rdata = st_r.home_val;
        aehl_pkg::ADDR_POSITION: st_nxt.rdata = count;
        aehl_pkg::ADDR_HOME_PAT: st_nxt.rdata = 32'(st_r.home_pat);
        aehl_pkg::ADDR_SLIP_TOL: st_nxt.rdata = st_r.slip_tol;
        aehl_pkg::ADDR_GEAR:     st_nxt.rdata = 32'(st_r.gear);
        aehl_pkg::ADDR_STATUS: begin
          st_nxt.rdata = 32'({bad_step, home_act, st_r.lim_neg_act,
                              st_r.lim_pos_act});
        end
        aehl_pkg::ADDR_IRQ_STAT: begin
          st_nxt.rdata    = 32'(st_r.irq_stat);
          st_nxt.irq_stat = '0;
        end
        aehl_pkg::ADDR_IRQ_MASK: st_nxt.rdata = 32'(st_r.irq_mask);
        default:                 st_nxt.rdata = 32'h0000_0000;
      endcase
    end
    // events set after any clear so a same-cycle event survives
    ev = '0;
    ev[aehl_pkg::IRQ_LIMIT]   = (st_nxt.lim_pos_act && !st_r.lim_pos_act)
                                || (st_nxt.lim_neg_act && !st_r.lim_neg_act);
    ev[aehl_pkg::IRQ_HOME]    = home_evt;
    ev[aehl_pkg::IRQ_SLIP]    = st_nxt.slip && !st_r.slip;
    ev[aehl_pkg::IRQ_CORRECT] = st_nxt.corr_valid;
    st_nxt.irq_stat = st_nxt.irq_stat | ev;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      st_r          <= '0;
      st_r.ctrl     <= aehl_pkg::CTRL_RST;
      st_r.home_pat <= aehl_pkg::HOME_PAT_RST;
      st_r.slip_tol <= aehl_pkg::SLIP_TOL_RST;
      st_r.gear     <= aehl_pkg::GEAR_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign EXCITE_EN      = !(st_r.lim_pos_act || st_r.lim_neg_act);
  assign HOME_STOP_RAMP = st_r.stop_ramp;
  assign HOME_STOP_NOW  = st_r.stop_now;
  assign HOME_DIR       = st_r.ctrl[aehl_pkg::CTRL_HOME_DIR];
  assign ENC_POS        = count;
  assign POS_ERR        = st_r.pos_err;
  assign SLIP           = st_r.slip;
  assign CORR_VALID     = st_r.corr_valid;
  assign CORR_AMT       = st_r.corr_amt;
  assign TRACK_TARGET   = st_r.track;
  assign IRQ            = |(st_r.irq_stat & st_r.irq_mask);
  assign S_AXI_AWREADY  = !st_r.aw_got && !st_r.bvalid;
  assign S_AXI_WREADY   = !st_r.w_got && !st_r.bvalid;
  assign S_AXI_BVALID   = st_r.bvalid;
  assign S_AXI_BRESP    = st_r.bresp;
  assign S_AXI_ARREADY  = !st_r.rvalid;
  assign S_AXI_RVALID   = st_r.rvalid;
  assign S_AXI_RDATA    = st_r.rdata;
  assign S_AXI_RRESP    = st_r.rresp;
endmodule : aehl_axis
`default_nettype wire

/* File: core/aehl_pkg.sv */
// constants for the axis encoder, home and limit block
package aehl_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_HOME_VAL = 8'h04;
  localparam logic [7:0] ADDR_POSITION = 8'h08;
  localparam logic [7:0] ADDR_HOME_PAT = 8'h0c;
  localparam logic [7:0] ADDR_SLIP_TOL = 8'h10;
  localparam logic [7:0] ADDR_GEAR     = 8'h14;
  localparam logic [7:0] ADDR_STATUS   = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
  // control register fields
  localparam int CTRL_LIM_POS_HI  = 0;
  localparam int CTRL_LIM_NEG_HI  = 1;
  localparam int CTRL_HOME_HI     = 2;
  localparam int CTRL_HOME_ENC    = 3;
  localparam int CTRL_INV_A       = 4;
  localparam int CTRL_INV_B       = 5;
  localparam int CTRL_SWAP_AB     = 6;
  localparam int CTRL_STOP_NOW    = 7;
  localparam int CTRL_HOME_ARM    = 8;
  localparam int CTRL_HOME_DIR    = 9;
  localparam int CTRL_SLIP_EN     = 10;
  localparam int CTRL_TRACK_EN    = 11;
  localparam int CTRL_CORRECT_EN  = 12;
  localparam int CTRL_W           = 13;
  // interrupt status fields
  localparam int IRQ_LIMIT   = 0;
  localparam int IRQ_HOME    = 1;
  localparam int IRQ_SLIP    = 2;
  localparam int IRQ_CORRECT = 3;
  localparam int IRQ_W       = 4;
  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST     = 13'h0000;
  localparam logic [2:0]        HOME_PAT_RST = 3'h5;
  localparam logic [31:0]       SLIP_TOL_RST = 32'h0000_0100;
  localparam logic [15:0]       GEAR_RST     = 16'h0001;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : aehl_pkg

/* File: core/aehl_quad.sv */
// times-four quadrature decoder with loadable position counter
`timescale 1ns/1ns
`default_nettype none
module aehl_quad (
  input  wire logic        SYS_CLK,
  input  wire logic        RESETN,
  input  wire logic        PHA,
  input  wire logic        PHB,
  input  wire logic        LOAD,
  input  wire logic [31:0] LOAD_VAL,
  output logic      [31:0] COUNT,
  output logic             BAD_STEP
);
  typedef struct packed {
    logic        a;
    logic        b;
    logic [31:0] cnt;
    logic        bad;
  } aehl_quad_st_t;

  aehl_quad_st_t st_r;
  aehl_quad_st_t st_nxt;

  // one count per phase edge; both phases moving at once is dropped
  always_comb begin
    st_nxt     = st_r;
    st_nxt.a   = PHA;
    st_nxt.b   = PHB;
    st_nxt.bad = 1'b0;
    case ({st_r.a, st_r.b, PHA, PHB})
      4'h2, 4'hb, 4'hd, 4'h4: st_nxt.cnt = st_r.cnt + 32'h1;
      4'h1, 4'h7, 4'he, 4'h8: st_nxt.cnt = st_r.cnt - 32'h1;
      4'h3, 4'h6, 4'h9, 4'hc: st_nxt.bad = 1'b1;
      default: st_nxt.cnt = st_r.cnt;
    endcase
    if (LOAD) begin
      st_nxt.cnt = LOAD_VAL;
    end
  end

  // a full decode every clock keeps up with 16 MHz count rates
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign COUNT    = st_r.cnt;
  assign BAD_STEP = st_r.bad;
endmodule : aehl_quad
`default_nettype wire

/* File: core/aehl_home.sv */
// home switch and home-encoder event detector
`timescale 1ns/1ns
`default_nettype none
module aehl_home (
  input  wire logic       SYS_CLK,
  input  wire logic       RESETN,
  input  wire logic       ENC_MODE,
  input  wire logic       HOME_HI,
  input  wire logic [2:0] PATTERN,
  input  wire logic       PHA,
  input  wire logic       PHB,
  input  wire logic       INDEX,
  input  wire logic       HOME_IN,
  input  wire logic       ARMED,
  output logic            HOME_ACT,
  output logic            HOME_EVT
);
  typedef struct packed {
    logic act;
    logic cond;
    logic evt;
  } aehl_home_st_t;

  aehl_home_st_t st_r;
  aehl_home_st_t st_nxt;
  logic          sw_act;
  logic          cond;

  always_comb begin
    sw_act = (HOME_IN == HOME_HI);
    cond   = sw_act;
    if (ENC_MODE) begin
      // pattern is {index, phase b, phase a}
      cond = sw_act && (PHA == PATTERN[0]) && (PHB == PATTERN[1])
             && (INDEX == PATTERN[2]);
    end
    st_nxt      = st_r;
    st_nxt.act  = sw_act;
    st_nxt.cond = cond;
    st_nxt.evt  = ARMED && cond && !st_r.cond;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign HOME_ACT = st_r.act;
  assign HOME_EVT = st_r.evt;
endmodule : aehl_home
`default_nettype wire

/* File: sim/aehl_axis_chk.sv */
// concurrent checks on the axis feedback block ports
`timescale 1ns/1ns
`default_nettype none
module aehl_axis_chk (
  input wire logic        SYS_CLK,
  input wire logic        RESETN,
  input wire logic [31:0] ENC_POS,
  input wire logic [31:0] POS_ERR,
  input wire logic [31:0] COMMAND_POS,
  input wire logic        MOVE_DONE,
  input wire logic        CORR_VALID,
  input wire logic        HOME_STOP_RAMP,
  input wire logic        HOME_STOP_NOW,
  input wire logic        HOME_DIR,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);

  stop_excl_a: assert property (
    !(HOME_STOP_RAMP && HOME_STOP_NOW))
    else $error("both stop responses at once");
  stop_pulse_a: assert property (
    (HOME_STOP_RAMP || HOME_STOP_NOW) |=> !HOME_STOP_RAMP && !HOME_STOP_NOW)
    else $error("home stop longer than one cycle");
  count_step_a: assert property (
    $past(RESETN) && !$past(HOME_STOP_RAMP) && !$past(HOME_STOP_NOW)
    |-> (ENC_POS - $past(ENC_POS)) inside {32'h0, 32'h1, 32'hffff_ffff})
    else $error("position moved by more than one count");
  err_calc_a: assert property (
    $past(RESETN) |-> POS_ERR == $past(COMMAND_POS) - $past(ENC_POS))
    else $error("position error not command minus position");
  corr_cause_a: assert property (
    CORR_VALID |-> $past(MOVE_DONE) && !$past(MOVE_DONE, 2))
    else $error("correction without move end");
  corr_once_a: assert property (
    CORR_VALID |=> !CORR_VALID)
    else $error("correction pulse too long");
  dir_by_write_a: assert property (
    $changed(HOME_DIR) |-> $rose(S_AXI_BVALID))
    else $error("home direction changed without a write");
  bresp_done_a: assert property (
    S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write response not retired");
  rresp_done_a: assert property (
    S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read response not retired");
endmodule : aehl_axis_chk

bind aehl_axis aehl_axis_chk u_chk (.*);
`default_nettype wire

/* File: sim/aehl_enc_model.sv */
// quadrature encoder, index, home and limit switch model
`timescale 1ns/1ns
`default_nettype none
module aehl_enc_model (
  input  wire logic clk,
  output logic      pha,
  output logic      phb,
  output var logic  index,
  output var logic  home,
  output var logic  lim_p,
  output var logic  lim_n
);
  logic [1:0] q = 2'h0;
  // state order 00,10,11,01 is a positive move
  assign pha = q[0] ^ q[1];
  assign phb = q[1];
  initial begin
    index = 1'b0;
    home  = 1'b1;
    lim_p = 1'b1;
    lim_n = 1'b1;
  end
  // seven cycles a count keeps near the top count rate
  task automatic step(input bit up, input int n);
    repeat (n) begin
      @(posedge clk);
      q <= up ? q + 2'h1 : q - 2'h1;
      repeat (6) @(posedge clk);
    end
  endtask : step
  // both phases change together
  task automatic jolt();
    @(posedge clk);
    q <= q + 2'h2;
    repeat (6) @(posedge clk);
  endtask : jolt
  task automatic home_pulse();
    @(posedge clk);
    home <= 1'b1;
    repeat (16) @(posedge clk);
    home <= 1'b0;
  endtask : home_pulse
endmodule : aehl_enc_model
`default_nettype wire

/* File: sim/aehl_axis_test.sv */
// register level tests of the axis feedback block
`timescale 1ns/1ns
`default_nettype none
module aehl_axis_test;
  logic        SYS_CLK, RESETN, MOVE_DONE, IRQ, SLIP, CORR_VALID;
  logic        ENC_A, ENC_B, ENC_INDEX, HOME_SW, LIMIT_POS, LIMIT_NEG;
  logic        EXCITE_EN, HOME_STOP_RAMP, HOME_STOP_NOW, HOME_DIR;
  logic [31:0] COMMAND_POS, ENC_POS, POS_ERR, CORR_AMT, TRACK_TARGET;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0]  S_AXI_WSTRB;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
  logic        S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
  logic        S_AXI_RVALID, S_AXI_RREADY;
  int          n_errors, checks_done, n_ramp, n_now, n_corr;

  aehl_axis DUT (.*);
  aehl_enc_model enc (.clk(SYS_CLK), .pha(ENC_A), .phb(ENC_B),
    .index(ENC_INDEX), .home(HOME_SW), .lim_p(LIMIT_POS), .lim_n(LIMIT_NEG));

  initial begin
    SYS_CLK = 1'b0;
    forever #4 SYS_CLK = ~SYS_CLK;
  end

  always @(posedge SYS_CLK) begin
    if (HOME_STOP_RAMP === 1'b1) n_ramp++;
    if (HOME_STOP_NOW === 1'b1) n_now++;
    if (CORR_VALID === 1'b1) n_corr++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge SYS_CLK);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = aehl_pkg::RESP_OKAY);
    bit aw, w;
    aw = 1'b0;
    w = 1'b0;
    // one edge between calls keeps bready from toggling in one step
    @(posedge SYS_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    while (!(aw && w)) begin
      @(posedge SYS_CLK);
      if (!aw && S_AXI_AWREADY === 1'b1) begin
        aw = 1'b1;
        S_AXI_AWVALID <= 1'b0;
      end
      if (!w && S_AXI_WREADY === 1'b1) begin
        w = 1'b1;
        S_AXI_WVALID <= 1'b0;
      end
    end
    do @(posedge SYS_CLK); while (S_AXI_BVALID !== 1'b1);
    S_AXI_BREADY <= 1'b0;
    chk(32'(S_AXI_BRESP), 32'(er));
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er = aehl_pkg::RESP_OKAY);
    @(posedge SYS_CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do @(posedge SYS_CLK); while (S_AXI_ARREADY !== 1'b1);
    S_AXI_ARVALID <= 1'b0;
    do @(posedge SYS_CLK); while (S_AXI_RVALID !== 1'b1);
    S_AXI_RREADY <= 1'b0;
    chk(S_AXI_RDATA, e);
    chk(32'(S_AXI_RRESP), 32'(er));
  endtask : rd

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (20000) @(posedge SYS_CLK);
    n_errors++;
    end_of_test();
  end

  initial begin
    RESETN = 1'b0;
    MOVE_DONE = 1'b0;
    COMMAND_POS = 32'h0;
    S_AXI_AWADDR = 8'h0;
    S_AXI_ARADDR = 8'h0;
    S_AXI_WDATA = 32'h0;
    S_AXI_WSTRB = 4'hf;
    S_AXI_AWVALID = 1'b0;
    S_AXI_WVALID = 1'b0;
    S_AXI_BREADY = 1'b0;
    S_AXI_ARVALID = 1'b0;
    S_AXI_RREADY = 1'b0;
    cyc(16);
    RESETN <= 1'b1;
    cyc(2);
    chk(32'(EXCITE_EN), 32'h1);
    chk(32'(IRQ), 32'h0);
    rd(aehl_pkg::ADDR_HOME_PAT, 32'h5);
    rd(aehl_pkg::ADDR_SLIP_TOL, 32'h100);
    rd(aehl_pkg::ADDR_GEAR, 32'h1);
    rd(8'h24, 32'h0, aehl_pkg::RESP_SLVERR);
    wr(8'h24, 32'h1, aehl_pkg::RESP_SLVERR);
    $display("test reset done");
    enc.step(1, 8);
    rd(aehl_pkg::ADDR_POSITION, 32'h8);
    enc.step(0, 3);
    rd(aehl_pkg::ADDR_POSITION, 32'h5);
    enc.step(1, 3);
    enc.jolt();
    enc.jolt();
    rd(aehl_pkg::ADDR_POSITION, 32'h8);
    wr(aehl_pkg::ADDR_CTRL, 32'h40);
    enc.step(1, 2);
    rd(aehl_pkg::ADDR_POSITION, 32'h6);
    enc.step(0, 2);
    wr(aehl_pkg::ADDR_CTRL, 32'h0);
    rd(aehl_pkg::ADDR_POSITION, 32'h8);
    // inverting a at rest is itself one up count
    wr(aehl_pkg::ADDR_CTRL, 32'h10);
    enc.step(1, 2);
    rd(aehl_pkg::ADDR_POSITION, 32'h7);
    enc.step(0, 2);
    wr(aehl_pkg::ADDR_CTRL, 32'h0);
    rd(aehl_pkg::ADDR_POSITION, 32'h8);
    chk(ENC_POS, 32'h8);
    $display("test decoder done");
    wr(aehl_pkg::ADDR_IRQ_MASK, 32'h0);
    for (int i = 0; i < 2; i++) begin
      {enc.lim_n, enc.lim_p} <= (i == 0) ? 2'b10 : 2'b01;
      cyc(3);
      chk(32'(EXCITE_EN), 32'h0);
      rd(aehl_pkg::ADDR_STATUS, 32'h1 << i);
      wr(aehl_pkg::ADDR_CTRL, 32'h1 << i);
      cyc(2);
      chk(32'(EXCITE_EN), 32'h1);
      wr(aehl_pkg::ADDR_CTRL, 32'h0);
      {enc.lim_n, enc.lim_p} <= 2'b11;
      cyc(3);
      chk(32'(EXCITE_EN), 32'h1);
    end
    chk(32'(IRQ), 32'h0);
    wr(aehl_pkg::ADDR_IRQ_MASK, 32'h1);
    cyc(2);
    chk(32'(IRQ), 32'h1);
    rd(aehl_pkg::ADDR_IRQ_STAT, 32'h1);
    cyc(2);
    chk(32'(IRQ), 32'h0);
    $display("test limits done");
    enc.home <= 1'b0;
    for (int m = 0; m < 2; m++) begin
      wr(aehl_pkg::ADDR_HOME_VAL, 32'h1234 + 32'(m));
      wr(aehl_pkg::ADDR_CTRL, 32'h304 | (32'(m) << 7));
      cyc(2);
      chk(32'(HOME_DIR), 32'h1);
      enc.home_pulse();
      chk(32'(n_ramp), 32'h1);
      chk(32'(n_now), 32'(m));
      rd(aehl_pkg::ADDR_POSITION, 32'h1234 + 32'(m));
    end
    $display("test switch home done");
    wr(aehl_pkg::ADDR_HOME_VAL, 32'h99);
    wr(aehl_pkg::ADDR_CTRL, 32'h10c);
    // index spans two quadrants, 00 and 10, inside one turn
    enc.index <= 1'b1;
    enc.home <= 1'b1;
    cyc(8);
    chk(32'(n_ramp), 32'h1);
    enc.step(1, 1);
    chk(32'(n_ramp), 32'h2);
    rd(aehl_pkg::ADDR_POSITION, 32'h99);
    enc.index <= 1'b0;
    enc.home <= 1'b0;
    $display("test encoder home done");
    COMMAND_POS <= 32'h300;
    cyc(3);
    chk(POS_ERR, 32'h267);
    wr(aehl_pkg::ADDR_CTRL, 32'h1c00);
    cyc(2);
    chk(32'(SLIP), 32'h1);
    chk(TRACK_TARGET, 32'h99);
    MOVE_DONE <= 1'b1;
    cyc(3);
    chk(32'(n_corr), 32'h1);
    chk(CORR_AMT, 32'h267);
    MOVE_DONE <= 1'b0;
    chk(32'(IRQ), 32'h0);
    rd(aehl_pkg::ADDR_IRQ_STAT, 32'he);
    $display("test correction done");
    end_of_test();
  end
endmodule : aehl_axis_test
`default_nettype wire
